// File: bps_sequencer.sv
// burst pulse sequencer: eight burst channels, those with a nonzero count visited in turn on the main clock
// assumes all inputs synchronous to the base oscillator clock i_clock
`timescale 1ns/1ps
`default_nettype none
module bps_sequencer
	import bps_pkg::*;
#(
	parameter int NUM_CH = BPS_NUM_CH,
	parameter int LEN_W = BPS_LEN_W,
	parameter int DIV_W = BPS_DIV_W
)
(
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	input wire logic [DIV_W-1:0] i_divider,
	input wire logic [NUM_CH*LEN_W-1:0] i_burst_len,
	input wire logic [NUM_CH-1:0] i_burst_out_en,
	input wire logic [NUM_CH-1:0] i_sync_en,
	output logic [NUM_CH-1:0] o_channel,
	output logic o_sync,
	output logic [BPS_CH_IDX_W-1:0] o_phase
);
	logic main_tick;
	logic [BPS_CH_IDX_W-1:0] phase;
	logic [LEN_W-1:0] count;
	logic [NUM_CH-1:0] fire;
	logic [NUM_CH-1:0] next_channel;
	logic next_sync;
	logic [BPS_CH_IDX_W-1:0] next_phase;
	logic [LEN_W-1:0] next_count;
	wire logic [NUM_CH-1:0] nonzero;
	wire logic [LEN_W-1:0] cur_len;
	wire logic burst_done;

	function automatic logic [LEN_W-1:0] len_of(input logic [NUM_CH*LEN_W-1:0] lens,
		input logic [BPS_CH_IDX_W-1:0] ch);
		len_of = lens[ch*LEN_W +: LEN_W];
	endfunction

	// nearest channel at or before ch, cyclically, with a nonzero count
	function automatic logic [BPS_CH_IDX_W-1:0] owner_of(input logic [NUM_CH-1:0] nz,
		input logic [BPS_CH_IDX_W-1:0] ch);
		logic [BPS_CH_IDX_W-1:0] k;
		owner_of = ch;
		k = ch;
		for (int i = 0; i < NUM_CH; i++)
		begin
			if (nz[k])
			begin
				owner_of = k;
				break;
			end
			k = k - BPS_CH_IDX_W'(1);
		end
	endfunction

	// next channel after ch, in order 0..7 with wrap, that takes its own turn
	function automatic logic [BPS_CH_IDX_W-1:0] next_turn(input logic [NUM_CH-1:0] nz,
		input logic [BPS_CH_IDX_W-1:0] ch);
		logic [BPS_CH_IDX_W-1:0] k;
		next_turn = ch;
		k = ch;
		for (int i = 0; i < NUM_CH; i++)
		begin
			k = k + BPS_CH_IDX_W'(1);
			if (nz[k])
			begin
				next_turn = k;
				break;
			end
		end
	endfunction

	bps_divider #(
		.DIV_W(DIV_W)
	) u_divider (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_clk_en(i_clk_en),
		.i_divider(i_divider),
		.o_tick(main_tick)
	);

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++)
		begin : g_nz
			assign nonzero[g] = (i_burst_len[g*LEN_W +: LEN_W] != '0);
		end
	endgenerate

	assign cur_len = len_of(i_burst_len, phase);
	assign burst_done = (count + LEN_W'(1) >= cur_len);

	always_comb
	begin
		fire = '0;
		for (int j = 0; j < NUM_CH; j++)
		begin
			// zero count channels share the pulses of the nearest nonzero channel before them, cyclically
			fire[j] = nonzero[owner_of(nonzero, BPS_CH_IDX_W'(j))] &&
				(owner_of(nonzero, BPS_CH_IDX_W'(j)) == phase) && nonzero[phase];
		end
	end

	always_comb
	begin
		next_phase = phase;
		next_count = count;
		next_channel = '0;
		next_sync = 1'b0;
		if (main_tick)
		begin
			next_channel = fire & i_burst_out_en;
			next_sync = |(fire & i_sync_en);
			if (!nonzero[phase] || burst_done)
			begin
				next_count = BPS_COUNT_RST;
				next_phase = next_turn(nonzero, phase);
			end
			else
			begin
				next_count = count + LEN_W'(1);
			end
		end
	end

	// outputs pulse high for one base clock when the divider is above one; the falling edge is the trigger
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			phase <= BPS_PHASE_RST;
			count <= BPS_COUNT_RST;
			o_channel <= '0;
			o_sync <= 1'b0;
			o_phase <= BPS_PHASE_RST;
		end
		else if (i_clk_en)
		begin
			phase <= next_phase;
			count <= next_count;
			o_channel <= next_channel;
			o_sync <= next_sync;
			o_phase <= phase;
		end
	end
endmodule
`default_nettype wire

// File: bps_pkg.sv
// constants shared by the burst pulse sequencer and its main clock divider
// assumes a single base oscillator clock drives every file
package bps_pkg;
	localparam int BPS_NUM_CH = 8;
	localparam int BPS_CH_IDX_W = 3;
	localparam int BPS_LEN_W = 8;
	localparam int BPS_DIV_W = 8;
	localparam int BPS_BASE_MHZ = 80;
	localparam logic [BPS_CH_IDX_W-1:0] BPS_PHASE_RST = 3'h0;
	localparam logic [BPS_LEN_W-1:0] BPS_COUNT_RST = 8'h00;
	localparam logic [BPS_DIV_W-1:0] BPS_DIV_MIN = 8'h01;
endpackage

// File: bps_divider.sv
// main clock divider: one tick every divider base clocks
// assumes the divider value is static between updates; zero is taken as one
`timescale 1ns/1ps
`default_nettype none
module bps_divider
	import bps_pkg::*;
#(
	parameter int DIV_W = BPS_DIV_W
)
(
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	input wire logic [DIV_W-1:0] i_divider,
	output logic o_tick
);
	logic [DIV_W-1:0] count;
	wire logic [DIV_W-1:0] div_eff;
	wire logic wrap;

	// values below one are clamped, so one passes the base rate through
	assign div_eff = (i_divider < DIV_W'(BPS_DIV_MIN)) ? DIV_W'(BPS_DIV_MIN) : i_divider;
	assign wrap = (count >= div_eff - DIV_W'(1));

	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			count <= '0;
			o_tick <= 1'b0;
		end
		else if (i_clk_en)
		begin
			count <= wrap ? '0 : count + DIV_W'(1);
			o_tick <= wrap;
		end
	end
endmodule
`default_nettype wire

// File: bps_chk.sv
// checker on the sequencer ports, bound below
// assumes frozen cycles (clock enable low) are skipped through the disable condition
`timescale 1ns/1ps
`default_nettype none
module bps_chk
(
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	input wire logic [7:0] i_divider,
	input wire logic [63:0] i_burst_len,
	input wire logic [7:0] i_burst_out_en,
	input wire logic [7:0] i_sync_en,
	input wire logic [7:0] o_channel,
	input wire logic o_sync,
	input wire logic [2:0] o_phase
);
	wire [7:0] rot = {o_channel[6:0], o_channel[7]};
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n || !i_clk_en);
	chk_out_gate: assert property (!(o_channel & ~$past(i_burst_out_en))) else $error("gate");
	chk_sync_set: assert property ((o_channel & $past(i_sync_en)) != 8'h00 |-> o_sync) else $error("sync");
	chk_sync_cause: assert property (o_sync |-> |$past(i_sync_en)) else $error("cause");
	chk_pulse_rate: assert property (|o_channel && i_divider > 8'h01 |=> !o_channel) else $error("rate");
	chk_tick_gap: assert property ($rose(|o_channel) && i_divider == 8'h04 |=> !o_channel [*3]) else $error("gap");
	chk_turn_next: assert property ($onehot(o_channel) && &i_burst_out_en && i_divider == 8'h04
		&& i_burst_len == {8{8'h01}} |-> ##4 o_channel == $past(rot, 4)) else $error("turn");
	chk_split_all: assert property (|o_channel && i_burst_len == 64'h01 |-> o_channel == i_burst_out_en)
		else $error("split");
	chk_zero_copy: assert property (o_channel[1] && !i_burst_len[15:8] && i_burst_out_en[0] |-> o_channel[0])
		else $error("copy");
	chk_phase_track: assert property ($onehot(o_channel) && &i_burst_out_en && i_burst_len == {8{8'h01}}
		|-> o_channel == (8'h01 << o_phase)) else $error("phase");
endmodule
bind bps_sequencer bps_chk bps_chk_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en),
	.i_divider(i_divider), .i_burst_len(i_burst_len), .i_burst_out_en(i_burst_out_en), .i_sync_en(i_sync_en),
	.o_channel(o_channel), .o_sync(o_sync), .o_phase(o_phase));
`default_nettype wire

// File: bps_drv.sv
// bank of laser drivers, one per trigger line
// assumes glitch-free lines sampled on the base clock
`timescale 1ns/1ps
`default_nettype none
module bps_drv
(
	input wire logic i_clock,
	input wire logic [8:0] i_trig,
	output logic [8:0] o_fired
);
	logic [8:0] last = 9'h000;
	assign o_fired = last & ~i_trig;
	always @(posedge i_clock)
		last <= i_trig;
endmodule
`default_nettype wire

// File: test_burst_pulse_sequencer.sv
// bench: trigger falls counted per output and sync line
// assumes the bound checker and default widths
`timescale 1ns/1ps
`default_nettype none
module test_burst_pulse_sequencer;
	logic i_clock = 1'b0;
	logic i_rst_n = 1'b0;
	logic en = 1'b1;
	logic [87:0] cf = 88'h0;
	wire [8:0] tr;
	wire [8:0] fl;
	logic [7:0] n [9];
	int bad_count = 0;
	int checks = 0;
	always #5 i_clock = ~i_clock;
	bps_sequencer bps_sequencer_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_clk_en(en), .i_divider(cf[87:80]),
		.i_burst_len(cf[79:16]), .i_burst_out_en(cf[15:8]), .i_sync_en(cf[7:0]), .o_channel(tr[7:0]),
		.o_sync(tr[8]), .o_phase());
	bps_drv bps_drv_i (.i_clock(i_clock), .i_trig(tr), .o_fired(fl));
	// counted on the rising edge so that reset, driven at the falling edge, is read without a race
	always @(posedge i_clock)
		for (int k = 0; k < 9; k++)
			n[k] <= i_rst_n ? n[k] + 8'(fl[k]) : 8'h00;
	task automatic cmp(input int k, input logic [7:0] e);
		checks++;
		if (n[k] !== e)
		begin
			bad_count++;
			$display("mismatch falls %0d expected %0d seen %0d", k, e, n[k]);
		end
	endtask
	// h: falling edges with clock enable held low, starting 41 cycles after release
	task automatic go(input logic [87:0] c, input logic [71:0] e, input int h);
		@(negedge i_clock);
		i_rst_n = 1'b0;
		cf = c;
		@(negedge i_clock);
		i_rst_n = 1'b1;
		repeat (41) @(negedge i_clock);
		if (h > 0)
		begin
			en = 1'b0;
			repeat (h) @(negedge i_clock);
			en = 1'b1;
		end
		repeat (282 - h) @(negedge i_clock);
		for (int k = 0; k < 9; k++)
			cmp(k, e[8*k+:8]);
	endtask
	task automatic t_seq();
		go({8'h04, {8{8'h01}}, 16'hffff}, {8'h50, {8{8'h0a}}}, 0);
	endtask
	task automatic t_mix();
		go({8'h04, 64'h030002, 16'h5a18}, 72'h30_0030003030002000, 0);
	endtask
	task automatic t_split();
		go({8'h02, 64'h01, 16'hffff}, {9{8'ha0}}, 0);
	endtask
	// 100 frozen cycles mid run: only 223 enabled edges remain, so 55 pulses
	task automatic t_hold();
		go({8'h04, {8{8'h01}}, 16'hffff}, {8'h37, 8'h06, {7{8'h07}}}, 100);
	endtask
	task automatic final_report();
		if (bad_count == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(negedge i_clock);
		t_seq();
		t_mix();
		t_split();
		t_hold();
		final_report();
	end
	initial
	begin
		#20000;
		bad_count++;
		final_report();
	end
endmodule
`default_nettype wire
